// *** rtl/gpio_pkg.sv ***
// Constants, register map and carrier types for the dual GPIO port.
// Assumes a 32-bit AXI4-Lite bus with one register per aligned word.
package gpio_pkg;
	// Register indices; byte address is four times the index.
	localparam logic [7:0] IDX_PORT_A_DATA = 8'h05;
	localparam logic [7:0] IDX_PORT_B_DATA = 8'h06;
	localparam logic [7:0] IDX_INT_CONTROL = 8'h0B;
	localparam logic [7:0] IDX_OPTION      = 8'h81;
	localparam logic [7:0] IDX_PORT_A_DIR  = 8'h85;
	localparam logic [7:0] IDX_PORT_B_DIR  = 8'h86;
	localparam logic [7:0] IDX_ANALOG_CFG  = 8'h9F;
	// Reset values.
	localparam logic [7:0] RST_OPTION     = 8'hFF;
	localparam logic [5:0] RST_PORT_A_DIR = 6'h3F;
	localparam logic [7:0] RST_PORT_B_DIR = 8'hFF;
	localparam logic [2:0] RST_ANALOG_CFG = 3'h0;
	localparam logic [7:0] RST_LATCH      = 8'h00;
	// Field positions.
	localparam int OPT_PULLUP_DIS_BIT = 7;
	localparam int INT_FLAG_BIT       = 0;
	localparam int PA_TIMER_BIT       = 4;
	localparam int PA_SELECT_BIT      = 5;
	localparam int PB_EXT_INT_BIT     = 0;
	localparam int PB_PROG_CLK_BIT    = 6;
	localparam int PB_PROG_DATA_BIT   = 7;
	localparam int CHG_LO             = 4;
	// Address word offset inside the byte address.
	localparam int ADDR_LSB = 2;
	// AXI response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Register access request from the bus slave to the core.
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] wr_idx;
		logic [7:0] rd_idx;
		logic [7:0] wdata;
	} reg_req_t;
	// Drive of one port: level and output enable per pin.
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} pin_drive_t;
endpackage : gpio_pkg

// *** rtl/pin_sync.sv ***
// Two-flop synchroniser for a vector of pin levels.
// Assumes each bit is an independent level from outside the clock.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int W = 8
) (
	// Clock and reset.
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Levels.
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	import gpio_pkg::*;
	logic [W-1:0] meta_reg; // First stage, read only by the second.

	// The first stage absorbs metastability; only sync_out is used.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule : pin_sync
`default_nettype wire

// *** rtl/axil_reg_slave.sv ***
// AXI4-Lite slave turning bus beats into single-cycle register requests.
// Assumes the core returns read data and decode status combinationally.
`timescale 1ns/1ps
`default_nettype none
module axil_reg_slave (
	// Clock and reset.
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// Write address and data.
	input  wire logic [31:0]      awaddr,
	input  wire logic             awvalid,
	output logic                  awready,
	input  wire logic [31:0]      wdata,
	input  wire logic [3:0]       wstrb,
	input  wire logic             wvalid,
	output logic                  wready,
	output logic [1:0]            bresp,
	output logic                  bvalid,
	input  wire logic             bready,
	// Read address and data.
	input  wire logic [31:0]      araddr,
	input  wire logic             arvalid,
	output logic                  arready,
	output logic [31:0]           rdata,
	output logic [1:0]            rresp,
	output logic                  rvalid,
	input  wire logic             rready,
	// Core side.
	output gpio_pkg::reg_req_t    req,
	input  wire logic [7:0]       rd_value,
	input  wire logic             rd_hit,
	input  wire logic             wr_hit
);
	import gpio_pkg::*;
	logic        aw_full_reg;  // Write address held.
	logic        w_full_reg;   // Write data held.
	logic [7:0]  aw_idx_reg;   // Held write index.
	logic [7:0]  w_data_reg;   // Held low byte.
	logic        w_lane_reg;   // Low byte lane enabled.
	logic        do_write;     // Both halves present.
	logic        do_read;      // Read address taken.

	// Accept each half only while its holder is empty and no answer waits.
	assign awready  = !aw_full_reg && !bvalid;
	assign wready   = !w_full_reg && !bvalid;
	assign arready  = !rvalid;
	assign do_write = aw_full_reg && w_full_reg;
	assign do_read  = arvalid && arready;

	// Requests to the core.
	always_comb begin
		req.wr     = do_write && w_lane_reg;
		req.wr_idx = aw_idx_reg;
		req.wdata  = w_data_reg;
		req.rd     = do_read;
		req.rd_idx = araddr[ADDR_LSB +: 8];
	end

	// Write channel holders and response.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
			aw_idx_reg  <= 8'h00;
			w_data_reg  <= 8'h00;
			w_lane_reg  <= 1'b0;
			bvalid      <= 1'b0;
			bresp       <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_full_reg <= 1'b1;
				aw_idx_reg  <= awaddr[ADDR_LSB +: 8];
			end
			if (wvalid && wready) begin
				w_full_reg <= 1'b1;
				w_data_reg <= wdata[7:0];
				w_lane_reg <= wstrb[0];
			end
			if (do_write) begin
				aw_full_reg <= 1'b0;
				w_full_reg  <= 1'b0;
				bvalid      <= 1'b1;
				bresp       <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Read channel: data are captured in the cycle the address is taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= RESP_OKAY;
		end else if (do_read) begin
			rvalid <= 1'b1;
			rdata  <= {24'h00_0000, rd_value};
			rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end
endmodule : axil_reg_slave
`default_nettype wire

// *** rtl/dual_gpio_port.sv ***
// Dual GPIO port: six-bit port A and eight-bit port B with change detect.
// Assumes an AXI4-Lite master, pins resolved by the surrounding wires,
// and a core that reports its sleep state as a level.
// Behaviour
// - Port B direction one: pin input, undriven.
// - Port B direction zero: drive latch bit.
// - Cleared pull-up control enables the pull-ups of all port B input pins.
// - Output pins never get a pull-up.
// - Option register resets to all ones.
// - Only inputs among B7..B4 compare.
// - Compare against copy taken at any read or write of port B.
// - OR of mismatches sets change flag.
// - Change event wakes the sleeping core.
// - Persisting mismatch keeps setting the flag.
// - Software ends mismatch, then clears flag.
// - B direction resets ones; latch reset.
// - Port A upper two bits read zero.
// - A4 is timer clock, open drain.
// - A5 supplies serial slave select.
// - B0 supplies external interrupt input.
// - B6, B7 carry programming clock, data.
// - Read gives pins, write loads latch.
// - Analog config selects shared pin roles.
// - After reset shared pins are analog.
`timescale 1ns/1ps
`default_nettype none
module dual_gpio_port #(
	parameter int A_WIDTH = 6,
	parameter int B_WIDTH = 8
) (
	// Clock and reset.
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write address and data.
	input  wire logic [31:0]       awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// AXI4-Lite read.
	input  wire logic [31:0]       araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// Port A pins.
	input  wire logic [5:0]        pa_in,
	output gpio_pkg::pin_drive_t   pa_drive,
	// Port B pins.
	input  wire logic [7:0]        pb_in,
	output gpio_pkg::pin_drive_t   pb_drive,
	output logic [7:0]             pb_pullup_en,
	// Core and peripheral links.
	input  wire logic              core_sleeping,
	input  wire logic              prog_mode,
	output logic                   wake_pulse,
	output logic                   port_change_flag,
	output logic                   timer_ext_clock_in,
	output logic                   ssp_slave_select,
	output logic                   ext_int_in,
	output logic                   prog_clock,
	output logic                   prog_data
);
	import gpio_pkg::*;

	// The register map and pin logic are written for the documented widths.
	if (A_WIDTH != 6 || B_WIDTH != 8) begin : g_width_check
		$error("dual_gpio_port supports only A_WIDTH 6 and B_WIDTH 8");
	end

	// Request from the bus slave.
	reg_req_t req;

	// Read path back into the slave.
	logic [7:0] rd_value;
	logic       rd_hit;
	logic       wr_hit;

	// Synchronised pin levels.
	logic [5:0] pa_sync;
	logic [7:0] pb_sync;

	// Software-visible registers.
	logic [5:0] pa_latch_reg;   // Port A output latch.
	logic [7:0] pb_latch_reg;   // Port B output latch.
	logic [5:0] pa_dir_reg;     // Port A direction, one is input.
	logic [7:0] pb_dir_reg;     // Port B direction, one is input.
	logic [7:0] option_reg;     // Option register.
	logic [2:0] analog_cfg_reg; // Analog pin configuration.
	logic       flag_reg;       // Port change flag.
	logic       flag_next;      // Next flag value.

	// Change detection state.
	logic [3:0] snap_reg;       // Copy of B7..B4 from the last access.
	logic [3:0] mismatch;       // Per-pin mismatch.
	logic       change_event;   // Any mismatch this cycle.
	logic       pb_access;      // Any read or write of port B.

	// Analog role per port A pin.
	logic [5:0] pa_analog;

	// Port A read view.
	logic [5:0] pa_view;

	// Bus slave.
	axil_reg_slave u_slave (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.awaddr   (awaddr),
		.awvalid  (awvalid),
		.awready  (awready),
		.wdata    (wdata),
		.wstrb    (wstrb),
		.wvalid   (wvalid),
		.wready   (wready),
		.bresp    (bresp),
		.bvalid   (bvalid),
		.bready   (bready),
		.araddr   (araddr),
		.arvalid  (arvalid),
		.arready  (arready),
		.rdata    (rdata),
		.rresp    (rresp),
		.rvalid   (rvalid),
		.rready   (rready),
		.req      (req),
		.rd_value (rd_value),
		.rd_hit   (rd_hit),
		.wr_hit   (wr_hit)
	);

	// Pins come from outside the clock, so both ports are synchronised.
	pin_sync #(.W(6)) u_sync_a (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in (pa_in),
		.sync_out (pa_sync)
	);

	pin_sync #(.W(8)) u_sync_b (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in (pb_in),
		.sync_out (pb_sync)
	);

	// Analog decode: pins 0..3 and 5 are shared with the converter.
	// Configuration zero makes all of them analog; seven makes all digital.
	always_comb begin
		case (analog_cfg_reg)
			3'h0:    pa_analog = 6'h2F;
			3'h1:    pa_analog = 6'h0F;
			3'h2:    pa_analog = 6'h0B;
			3'h3:    pa_analog = 6'h03;
			3'h4:    pa_analog = 6'h01;
			default: pa_analog = 6'h00;
		endcase
	end

	// Analog pins read as zero; digital pins show their level.
	assign pa_view = pa_sync & ~pa_analog;

	// Any bus access of port B refreshes the comparison copy.
	assign pb_access = (req.rd && req.rd_idx == IDX_PORT_B_DATA)
		|| (req.wr && req.wr_idx == IDX_PORT_B_DATA);

	// Read mux: unmapped indices answer with an error and zero data.
	always_comb begin
		rd_value = 8'h00;
		rd_hit   = 1'b1;
		case (req.rd_idx)
			IDX_PORT_A_DATA: rd_value = {2'h0, pa_view};
			IDX_PORT_B_DATA: rd_value = pb_sync;
			IDX_OPTION:      rd_value = option_reg;
			IDX_PORT_A_DIR:  rd_value = {2'h0, pa_dir_reg};
			IDX_PORT_B_DIR:  rd_value = pb_dir_reg;
			IDX_ANALOG_CFG:  rd_value = {5'h00, analog_cfg_reg};
			IDX_INT_CONTROL: rd_value = {7'h00, flag_reg};
			default:         rd_hit   = 1'b0;
		endcase
	end

	// Write decode status for the response.
	always_comb begin
		case (req.wr_idx)
			IDX_PORT_A_DATA, IDX_PORT_B_DATA, IDX_OPTION,
			IDX_PORT_A_DIR, IDX_PORT_B_DIR, IDX_ANALOG_CFG,
			IDX_INT_CONTROL: wr_hit = 1'b1;
			default:         wr_hit = 1'b0;
		endcase
	end

	// Output latches. A byte write loads the whole latch; the
	// read-modify-write of a bit operation is the processor's business.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pa_latch_reg <= RST_LATCH[5:0];
			pb_latch_reg <= RST_LATCH;
		end else if (req.wr) begin
			if (req.wr_idx == IDX_PORT_A_DATA) begin
				pa_latch_reg <= req.wdata[5:0];
			end
			if (req.wr_idx == IDX_PORT_B_DATA) begin
				pb_latch_reg <= req.wdata;
			end
		end
	end

	// Direction registers reset to all inputs.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pa_dir_reg <= RST_PORT_A_DIR;
			pb_dir_reg <= RST_PORT_B_DIR;
		end else if (req.wr) begin
			if (req.wr_idx == IDX_PORT_A_DIR) begin
				pa_dir_reg <= req.wdata[5:0];
			end
			if (req.wr_idx == IDX_PORT_B_DIR) begin
				pb_dir_reg <= req.wdata;
			end
		end
	end

	// Option and analog configuration registers.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			option_reg     <= RST_OPTION;
			analog_cfg_reg <= RST_ANALOG_CFG;
		end else if (req.wr) begin
			if (req.wr_idx == IDX_OPTION) begin
				option_reg <= req.wdata;
			end
			if (req.wr_idx == IDX_ANALOG_CFG) begin
				analog_cfg_reg <= req.wdata[2:0];
			end
		end
	end

	// Port B drive: each pin is its own small driver.
	for (genvar i = 0; i < 8; i++) begin : g_pb_pin
		// Direction one leaves the pin undriven.
		assign pb_drive.oe[i]  = !pb_dir_reg[i];
		// Direction zero puts the latch bit on the pin.
		assign pb_drive.out[i] = pb_latch_reg[i];
		// One global control, masked off for outputs.
		assign pb_pullup_en[i] = !option_reg[OPT_PULLUP_DIS_BIT]
			&& pb_dir_reg[i];
	end

	// Port A drive. Pin 4 is open drain: it can only pull low, so
	// a latch one with direction zero leaves the pin to its pull-up.
	for (genvar i = 0; i < 6; i++) begin : g_pa_pin
		if (i == PA_TIMER_BIT) begin : g_od
			assign pa_drive.oe[i]  = !pa_dir_reg[i] && !pa_latch_reg[i];
			assign pa_drive.out[i] = 1'b0;
		end else begin : g_pp
			assign pa_drive.oe[i]  = !pa_dir_reg[i];
			assign pa_drive.out[i] = pa_latch_reg[i];
		end
	end
	assign pa_drive.oe[7:6]  = 2'h0;
	assign pa_drive.out[7:6] = 2'h0;

	// Peripheral inputs taken from the synchronised pins.
	assign timer_ext_clock_in = pa_sync[PA_TIMER_BIT];
	assign ssp_slave_select   = pa_sync[PA_SELECT_BIT];
	assign ext_int_in         = pb_sync[PB_EXT_INT_BIT];

	// Programming lines are only passed on in programming mode.
	assign prog_clock = prog_mode && pb_sync[PB_PROG_CLK_BIT];
	assign prog_data  = prog_mode && pb_sync[PB_PROG_DATA_BIT];

	// Mismatch only counts on B7..B4 configured as inputs.
	assign mismatch = (pb_sync[7:CHG_LO] ^ snap_reg)
		& pb_dir_reg[7:CHG_LO];
	assign change_event = |mismatch;

	// The copy follows every access of port B. Polling therefore ends a mismatch,
	// but a change between reads still sets the flag, which stays set.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			snap_reg <= 4'h0;
		end else if (pb_access) begin
			snap_reg <= pb_sync[7:CHG_LO];
		end
	end

	// Flag: software writes the bit, but a live mismatch wins.
	always_comb begin
		flag_next = flag_reg;
		if (req.wr && req.wr_idx == IDX_INT_CONTROL) begin
			flag_next = req.wdata[INT_FLAG_BIT];
		end
		if (change_event) begin
			flag_next = 1'b1;
		end
	end

	// Flag register.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end
	assign port_change_flag = flag_reg;

	// Wake pulse on a change that arrives while the core sleeps.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wake_pulse <= 1'b0;
		end else begin
			wake_pulse <= core_sleeping && change_event && !wake_pulse;
		end
	end
endmodule : dual_gpio_port
`default_nettype wire

// *** verif/gpio_pin_model.sv ***
// Model of the circuits on the port pins: outside drivers, pull-ups, open lines.
// Assumes the bench chooses which lines the outside world drives, and their levels.
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_model (
	// Clock for the open-line pattern.
	input  wire logic                 aclk,
	// Device drive and pull-ups.
	input  wire gpio_pkg::pin_drive_t pa_drive,
	input  wire gpio_pkg::pin_drive_t pb_drive,
	input  wire logic [7:0]           pb_pullup_en,
	// Outside drivers chosen by the bench.
	input  wire logic [5:0]           ext_a_val,
	input  wire logic [5:0]           ext_a_en,
	input  wire logic [7:0]           ext_b_val,
	input  wire logic [7:0]           ext_b_en,
	// Resolved pin levels.
	output logic [5:0]                pa_in,
	output logic [7:0]                pb_in
);
	// An open line flips every cycle, so no level is trusted by luck.
	logic flt = 1'b0;
	always @(posedge aclk) flt <= ~flt;
	// The device driver wins, then the outside, then the pull-up.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pb_drive.oe[i]) pb_in[i] = pb_drive.out[i];
			else if (ext_b_en[i]) pb_in[i] = ext_b_val[i];
			else if (pb_pullup_en[i]) pb_in[i] = 1'b1;
			else pb_in[i] = flt;
		end
		for (int i = 0; i < 6; i++) begin
			if (pa_drive.oe[i]) pa_in[i] = pa_drive.out[i];
			else if (ext_a_en[i]) pa_in[i] = ext_a_val[i];
			else pa_in[i] = flt;
		end
	end
endmodule : gpio_pin_model
`default_nettype wire

// *** verif/dual_gpio_port_assertions.sv ***
// Checker for the dual GPIO port, watching only the pin and core ports.
// Assumes one clock domain and the two-flop pin synchroniser of the design.
`timescale 1ns/1ps
`default_nettype none
module gpio_port_checker (
	// Clock and reset.
	input wire logic                 aclk,
	input wire logic                 aresetn,
	// Pins.
	input wire logic [5:0]           pa_in,
	input wire gpio_pkg::pin_drive_t pa_drive,
	input wire logic [7:0]           pb_in,
	input wire gpio_pkg::pin_drive_t pb_drive,
	input wire logic [7:0]           pb_pullup_en,
	// Core and peripheral links.
	input wire logic                 core_sleeping,
	input wire logic                 prog_mode,
	input wire logic                 wake_pulse,
	input wire logic                 port_change_flag,
	input wire logic                 timer_ext_clock_in,
	input wire logic                 ssp_slave_select,
	input wire logic                 ext_int_in,
	input wire logic                 prog_clock,
	input wire logic                 prog_data
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// A driven pin never carries a pull-up.
	chk_pull_only_in: assert property (!(|(pb_pullup_en & pb_drive.oe)))
		else $error("pull-up on an output pin");
	// Pull-ups are all on for inputs or all off.
	chk_pull_global: assert property (pb_pullup_en == 8'h00 || pb_pullup_en == ~pb_drive.oe)
		else $error("pull-ups not switched together");
	// The timer pin only sinks, and the two top bits never drive.
	chk_open_drain: assert property (!pa_drive.out[4] && pa_drive.oe[7:6] == 2'h0)
		else $error("port A drives high on bit 4 or a missing bit");
	// Right after reset nothing drives and the pull-ups are off.
	chk_reset_state: assert property ($rose(aresetn) |->
		pb_drive.oe == 8'h00 && pa_drive.oe == 8'h00 && pb_pullup_en == 8'h00)
		else $error("pins not idle after reset");
	// A wake pulse needs a sleeping core and a raised change flag.
	chk_wake_cause: assert property (wake_pulse |-> $past(core_sleeping) && port_change_flag)
		else $error("wake without sleep or flag");
	// A wake pulse lasts one cycle.
	chk_wake_single: assert property (wake_pulse |=> !wake_pulse)
		else $error("wake pulse too long");
	// The synced pin levels arrive two edges late; the first two after reset are skipped.
	chk_ext_int_path: assert property ($past(aresetn) && $past(aresetn, 2) |->
		ext_int_in == $past(pb_in[0], 2))
		else $error("external interrupt input wrong");
	chk_alt_a_path: assert property ($past(aresetn) && $past(aresetn, 2) |->
		{ssp_slave_select, timer_ext_clock_in} == $past(pa_in[5:4], 2))
		else $error("timer clock or slave select wrong");
	chk_prog_gate: assert property ($past(aresetn) && $past(aresetn, 2) |->
		prog_clock == ($past(pb_in[6], 2) && prog_mode) &&
		prog_data == ($past(pb_in[7], 2) && prog_mode))
		else $error("programming lines wrong");
	cov_wake: cover property (wake_pulse);
	cov_flag: cover property ($rose(port_change_flag));
	cov_pull: cover property (pb_pullup_en != 8'h00);
	cov_sink: cover property (pa_drive.oe[4]);
endmodule : gpio_port_checker
bind dual_gpio_port gpio_port_checker u_chk (
	.aclk, .aresetn, .pa_in, .pa_drive, .pb_in, .pb_drive, .pb_pullup_en,
	.core_sleeping, .prog_mode, .wake_pulse, .port_change_flag,
	.timer_ext_clock_in, .ssp_slave_select, .ext_int_in, .prog_clock, .prog_data
);
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the dual GPIO port over AXI4-Lite.
// Assumes the pin model resolves every pin; bready and rready stay high.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import gpio_pkg::*;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] awaddr, wdata, araddr, rdata, last_d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, last_b, last_r;
	logic core_sleeping, prog_mode, wake_pulse, port_change_flag;
	logic timer_ext_clock_in, ssp_slave_select, ext_int_in, prog_clock, prog_data;
	logic [5:0] pa_in, ext_a_val, ext_a_en;
	logic [7:0] pb_in, ext_b_val, ext_b_en, pb_pullup_en, wakes;
	pin_drive_t pa_drive, pb_drive;
	int mismatches, total_checks;
	dual_gpio_port uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .pa_in, .pa_drive, .pb_in, .pb_drive,
		.pb_pullup_en, .core_sleeping, .prog_mode, .wake_pulse, .port_change_flag,
		.timer_ext_clock_in, .ssp_slave_select, .ext_int_in, .prog_clock, .prog_data);
	gpio_pin_model pins (.aclk, .pa_drive, .pb_drive, .pb_pullup_en, .ext_a_val,
		.ext_a_en, .ext_b_val, .ext_b_en, .pa_in, .pb_in);
	// Clock at 125 MHz.
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	// Counts wake pulses; updated by NBA so readers never race it.
	// Cleared while reset is held, so the counter has a single driver.
	always @(posedge aclk) begin
		if (!aresetn) wakes <= 8'h00;
		else if (wake_pulse === 1'b1) wakes <= wakes + 8'h01;
	end
	function automatic logic [31:0] ba(input logic [7:0] i);
		return {22'h0, i, 2'h0};
	endfunction : ba
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Address and data are offered together and each released when taken.
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		logic ta, tw;
		ta = 1'b1;
		tw = 1'b1;
		awaddr <= ba(i);
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (ta || tw) begin
			@(posedge aclk);
			if (ta && awready) awvalid <= 1'b0;
			if (tw && wready) wvalid <= 1'b0;
			ta = ta && !awready;
			tw = tw && !wready;
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		last_b = bresp;
	endtask : wr
	task automatic rd(input logic [7:0] i);
		araddr <= ba(i);
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		last_d = rdata;
		last_r = rresp;
	endtask : rd
	task automatic rc(input logic [7:0] i, input logic [7:0] e, input string nm);
		rd(i);
		chk(nm, e, last_d[7:0]);
	endtask : rc
	task automatic t_reset();
		rc(IDX_OPTION, 8'hFF, "option");
		rc(IDX_PORT_B_DIR, 8'hFF, "pb_dir");
		rc(IDX_PORT_A_DIR, 8'h3F, "pa_dir");
		rc(IDX_ANALOG_CFG, 8'h00, "analog_cfg");
		rc(IDX_PORT_A_DATA, 8'h10, "pa_analog_zero");
		chk("pb_oe", 8'h00, pb_drive.oe);
		chk("pull_en", 8'h00, pb_pullup_en);
	endtask : t_reset
	task automatic t_drive();
		ext_b_en <= 8'h0F;
		ext_b_val <= 8'h01;
		wr(IDX_PORT_B_DATA, 8'hA5);
		wr(IDX_PORT_B_DIR, 8'h0F);
		chk("pb_oe", 8'hF0, pb_drive.oe);
		chk("pb_out", 8'hA5, pb_drive.out);
		cyc(3);
		rc(IDX_PORT_B_DATA, 8'hA1, "pb_pins");
	endtask : t_drive
	task automatic t_pullup();
		wr(IDX_OPTION, 8'h7F);
		chk("pull_en", 8'h0F, pb_pullup_en);
		ext_b_en <= 8'h0D;
		cyc(3);
		rc(IDX_PORT_B_DATA, 8'hA3, "pb_pulled");
		wr(IDX_OPTION, 8'hFF);
		chk("pull_off", 8'h00, pb_pullup_en);
		ext_b_en <= 8'hFF;
		ext_b_val <= 8'h00;
		wr(IDX_PORT_B_DIR, 8'hFF);
	endtask : t_pullup
	task automatic t_change();
		cyc(3);
		rd(IDX_PORT_B_DATA);
		wr(IDX_INT_CONTROL, 8'h00);
		chk("flag_idle", 8'h00, {7'h0, port_change_flag});
		ext_b_val <= 8'h01;
		cyc(4);
		chk("flag_low_pin", 8'h00, {7'h0, port_change_flag});
		ext_b_val <= 8'h81;
		cyc(4);
		chk("flag_set", 8'h01, {7'h0, port_change_flag});
		wr(IDX_INT_CONTROL, 8'h00);
		rc(IDX_INT_CONTROL, 8'h01, "flag_stuck");
		rd(IDX_PORT_B_DATA);
		wr(IDX_INT_CONTROL, 8'h00);
		rc(IDX_INT_CONTROL, 8'h00, "flag_clear");
		wr(IDX_PORT_B_DATA, 8'h10);
		wr(IDX_PORT_B_DIR, 8'hEF);
		cyc(4);
		chk("flag_out_pin", 8'h00, {7'h0, port_change_flag});
		wr(IDX_PORT_B_DIR, 8'hFF);
		cyc(3);
		rd(IDX_PORT_B_DATA);
		wr(IDX_INT_CONTROL, 8'h00);
	endtask : t_change
	task automatic t_wake();
		chk("wake_awake", 8'h00, wakes);
		core_sleeping <= 1'b1;
		prog_mode <= 1'b1;
		ext_b_val <= 8'hA1;
		cyc(5);
		chk("wake_seen", 8'h01, {7'h0, wakes != 8'h00});
		chk("prog_data", 8'h01, {7'h0, prog_data});
		core_sleeping <= 1'b0;
		prog_mode <= 1'b0;
		rd(IDX_PORT_B_DATA);
		wr(IDX_INT_CONTROL, 8'h00);
	endtask : t_wake
	task automatic t_port_a();
		wr(IDX_ANALOG_CFG, 8'h07);
		rc(IDX_PORT_A_DATA, 8'h3F, "pa_digital");
		wr(IDX_ANALOG_CFG, 8'h04);
		rc(IDX_PORT_A_DATA, 8'h3E, "pa_mixed");
		wr(IDX_PORT_A_DIR, 8'hFF);
		rc(IDX_PORT_A_DIR, 8'h3F, "pa_dir_top");
		wr(IDX_PORT_A_DATA, 8'h10);
		wr(IDX_PORT_A_DIR, 8'h2F);
		chk("pa4_release", 8'h00, {7'h0, pa_drive.oe[4]});
		wr(IDX_PORT_A_DATA, 8'h00);
		chk("pa4_sink", 8'h01, {7'h0, pa_drive.oe[4]});
		cyc(3);
		rc(IDX_PORT_A_DATA, 8'h2E, "pa4_low");
	endtask : t_port_a
	// Unmapped words answer with an error and read as zero.
	task automatic t_unmapped();
		rd(8'hFF);
		chk("rresp", {6'h0, RESP_SLVERR}, {6'h0, last_r});
		chk("rdata", 8'h00, last_d[7:0]);
		wr(8'hFF, 8'h55);
		chk("bresp", {6'h0, RESP_SLVERR}, {6'h0, last_b});
	endtask : t_unmapped
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	// Cuts a hang short; the whole run needs well under a thousand cycles.
	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		report_and_stop();
	end
	initial begin
		{aresetn, awvalid, wvalid, arvalid, core_sleeping, prog_mode} = 6'h00;
		{bready, rready, wstrb} = 6'h3F;
		{awaddr, wdata, araddr} = 96'h0;
		{ext_a_val, ext_a_en, ext_b_val, ext_b_en} = 28'hFFF00FF;
		{mismatches, total_checks} = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_drive();
		t_pullup();
		t_change();
		t_wake();
		t_port_a();
		t_unmapped();
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
